/* can_ctrl_pkg.sv */
// Purpose: Shared constants and types for the CAN control option block
// Assumes: 32-bit APB, one aligned word per register
// Notes: Byte offsets are the APB byte addresses
package can_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET = 8'h0C;
  localparam logic [ADDR_W-1:0] TIMER_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] BUSOFF_OFFSET = 8'h14;

  // Control field positions
  localparam int DIVIDER_LSB = 24;
  localparam int ERR_MASK_BIT = 14;
  localparam int CLK_SEL_BIT = 13;
  localparam int LOOPBACK_BIT = 12;
  localparam int TRIPLE_BIT = 7;
  localparam int RECOVER_DIS_BIT = 6;
  localparam int TIMER_SYNC_BIT = 5;
  localparam int TX_ORDER_BIT = 4;

  localparam int EVENT_W = 5;
  localparam logic [EVENT_W-1:0] IRQ_ENABLE_RESET = 5'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [3:0] RECESSIVE_RUN = 4'hB;
  localparam logic [7:0] BUSOFF_SEQUENCES = 8'h80;

  typedef struct packed {
    logic [7:0] serial_clock_divider;
    logic error_irq_mask;
    logic prescaler_clock_select;
    logic loopback_enable;
    logic triple_sample_enable;
    logic busoff_autorecover_disable;
    logic timer_sync_on_buffer0;
    logic tx_order_by_buffer_index;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  // Sticky event bits, bit 0 is the error event
  typedef struct packed {
    logic busoff_exit;
    logic busoff_entry;
    logic rx_done;
    logic tx_done;
    logic error;
  } status_t;

  typedef enum {BUS_ON, BUS_OFF, BUS_REJOIN} busoff_state_t;

  function automatic logic [31:0] ctrl_to_word(input ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[DIVIDER_LSB +: 8] = c.serial_clock_divider;
    w[ERR_MASK_BIT] = c.error_irq_mask;
    w[CLK_SEL_BIT] = c.prescaler_clock_select;
    w[LOOPBACK_BIT] = c.loopback_enable;
    w[TRIPLE_BIT] = c.triple_sample_enable;
    w[RECOVER_DIS_BIT] = c.busoff_autorecover_disable;
    w[TIMER_SYNC_BIT] = c.timer_sync_on_buffer0;
    w[TX_ORDER_BIT] = c.tx_order_by_buffer_index;
    return w;
  endfunction : ctrl_to_word

  function automatic ctrl_t word_to_ctrl(input logic [31:0] w);
    ctrl_t c;
    c.serial_clock_divider = w[DIVIDER_LSB +: 8];
    c.error_irq_mask = w[ERR_MASK_BIT];
    c.prescaler_clock_select = w[CLK_SEL_BIT];
    c.loopback_enable = w[LOOPBACK_BIT];
    c.triple_sample_enable = w[TRIPLE_BIT];
    c.busoff_autorecover_disable = w[RECOVER_DIS_BIT];
    c.timer_sync_on_buffer0 = w[TIMER_SYNC_BIT];
    c.tx_order_by_buffer_index = w[TX_ORDER_BIT];
    return c;
  endfunction : word_to_ctrl

  function automatic logic majority3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : majority3

endpackage : can_ctrl_pkg

/* can_prescaler.sv */
// Purpose: Divides the selected source tick into time quantum ticks
// Assumes: src_tick is a one-cycle pulse on pclk
// Notes: Divider value N gives one quantum per N+1 source ticks
`timescale 1ns/1ps
module can_prescaler #(
  parameter int DIV_W = 8
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic src_tick, // Selected source clock tick
  input wire logic [DIV_W-1:0] divider, // Division factor minus one
  output logic tq_tick // One pulse per time quantum
);

  initial begin
    if (DIV_W < 1 || DIV_W > 16) $error("can_prescaler: DIV_W out of range");
  end

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic next_tq_tick;

  always_comb begin
    next_count = count;
    next_tq_tick = 1'b0;
    if (src_tick) begin
      if (count >= divider) begin
        next_count = '0;
        next_tq_tick = 1'b1;
      end else begin
        next_count = count + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tq_tick <= 1'b0;
    end else begin
      count <= next_count;
      tq_tick <= next_tq_tick;
    end
  end

  a_quantum_period: assert property (@(posedge pclk) disable iff (!presetn)
    src_tick && count == divider |=> tq_tick)
    else $error("quantum tick missing at divider terminal count");

endmodule : can_prescaler

/* can_control_options.sv */
// Purpose: CAN control options: clocking, sampling, loop-back, bus-off, timer, tx order
// Assumes: Protocol engine on pclk supplies bit, slot and event strobes
// Notes: APB slave with no wait states on any access
//
// Summary of operation
// - Error interrupt reaches irq only while the error mask bit 14 is set.
// - Bit 13 picks crystal input (0) or half bus clock (1) for prescaler.
// - Loop-back bit 12 feeds tx to rx, ignores rx pin, drives tx recessive.
// - Loop-back forces an internal dominant acknowledge in the ack slot.
// - Transmit and receive complete events still flag in loop-back.
// - Sampling bit 7 clear: one sample at end of phase segment 1.
// - Sampling bit 7 set: majority of three samples one quantum apart.
// - Recovery-disable bit 6 set holds bus off until software clears it.
// - Cleared before 128 recessive sequences: recover as if never set.
// - Cleared after 128 sequences: wait 11 more recessive bits then rejoin.
// - Setting the bit during a bus off acts only from the next entry.
// - Timer sync bit 5 resets the timer on reception into buffer 0.
// - Bit 4 clear: lowest identifier first; set: lowest buffer index first.
// - Quantum rate is source clock divided by divider plus one.
// - Free-running timer is 16 bits, wraps, advances per bit clock.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module can_control_options #(
  parameter int NUM_BUFFERS = 16,
  parameter int ID_W = 29
) (
  input wire logic pclk, // Bus clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [can_ctrl_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic crystal_clock_input, // Crystal clock pin
  input wire logic can_rx, // Receive pin from transceiver
  output logic can_tx, // Transmit pin to transceiver
  input wire logic tx_bit, // Transmitter bit stream
  input wire logic sample_point, // End of phase segment 1, on a quantum tick
  input wire logic ack_slot, // Ack slot bit in progress
  input wire logic bit_tick, // Bit clock pulse
  input wire logic error_event, // Protocol error pulse
  input wire logic tx_done, // Transmit complete pulse
  input wire logic rx_done, // Receive complete pulse
  input wire logic rx_buffer0_done, // Frame stored in buffer 0
  input wire logic busoff_entry, // Error counters reached bus off
  input wire logic [NUM_BUFFERS-1:0] tx_pending, // Buffers awaiting transmission
  input wire logic [NUM_BUFFERS-1:0][ID_W-1:0] tx_ids, // Identifier per buffer
  output logic tq_tick, // Time quantum pulse
  output logic rx_bit, // Decided received bit
  output logic rx_bit_valid, // Pulse with rx_bit
  output logic busoff, // Node is in bus off
  output logic [15:0] timer_value, // Free-running timer
  output logic [$clog2(NUM_BUFFERS)-1:0] tx_select, // Buffer to send next
  output logic tx_select_valid, // tx_select is meaningful
  output logic irq // Level interrupt
);

  localparam int SEL_W = $clog2(NUM_BUFFERS);

  initial begin
    if (NUM_BUFFERS < 2 || NUM_BUFFERS > 64) $error("NUM_BUFFERS out of range");
    if (ID_W < 1 || ID_W > 29) $error("ID_W out of range");
  end

  function automatic logic [SEL_W-1:0] pick_buffer(input logic [NUM_BUFFERS-1:0] pend,
      input logic [NUM_BUFFERS-1:0][ID_W-1:0] ids, input logic by_index);
    logic [SEL_W-1:0] sel;
    logic found;
    sel = '0;
    found = 1'b0;
    for (int i = 0; i < NUM_BUFFERS; i++) begin
      if (pend[i] && (!found || (!by_index && ids[i] < ids[sel]))) begin
        sel = SEL_W'(i);
        found = 1'b1;
      end
    end
    return sel;
  endfunction : pick_buffer

  // Register and APB state
  can_ctrl_pkg::ctrl_t ctrl, next_ctrl;
  can_ctrl_pkg::status_t status, next_status;
  logic [can_ctrl_pkg::EVENT_W-1:0] irq_enable, next_irq_enable;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic [can_ctrl_pkg::EVENT_W-1:0] clear_bits, eff_mask;
  logic wr_access;

  // Pin and sampler state
  logic rx_sync1, rx_sync2, xtal_sync1, xtal_sync2, xtal_prev, half_toggle;
  logic [1:0] sample_hist, next_sample_hist;
  logic next_rx_bit, next_rx_bit_valid, next_can_tx, rx_src, src_tick;

  // Bus off state
  can_ctrl_pkg::busoff_state_t bo_state, next_bo_state;
  logic latched_disable, next_latched_disable;
  logic [3:0] run_count, next_run_count;
  logic [7:0] seq_count, next_seq_count;
  logic next_busoff, exit_event;

  // Timer and tx order
  logic [15:0] next_timer_value;
  logic [SEL_W-1:0] next_tx_select;
  logic next_tx_select_valid;

  // APB: decode reads in setup and writes in the access cycle; answer in that access cycle
  always_comb begin
    wr_access = psel && penable && pready && pwrite;
    next_ctrl = ctrl;
    next_irq_enable = irq_enable;
    clear_bits = '0;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = psel && !penable;
    if (wr_access) begin
      unique case (paddr)
        can_ctrl_pkg::CTRL_OFFSET: next_ctrl = can_ctrl_pkg::word_to_ctrl(pwdata);
        can_ctrl_pkg::IRQ_ENABLE_OFFSET: next_irq_enable = pwdata[can_ctrl_pkg::EVENT_W-1:0];
        can_ctrl_pkg::IRQ_CLEAR_OFFSET: clear_bits = pwdata[can_ctrl_pkg::EVENT_W-1:0];
        default: ;
      endcase
    end
    if (psel && !penable) begin
      unique case (paddr)
        can_ctrl_pkg::CTRL_OFFSET: next_prdata = can_ctrl_pkg::ctrl_to_word(ctrl);
        can_ctrl_pkg::STATUS_OFFSET: next_prdata = {27'h0000000, status};
        can_ctrl_pkg::IRQ_ENABLE_OFFSET: next_prdata = {27'h0000000, irq_enable};
        can_ctrl_pkg::IRQ_CLEAR_OFFSET: next_prdata = 32'h0000_0000;
        can_ctrl_pkg::TIMER_OFFSET: next_prdata = {16'h0000, timer_value};
        can_ctrl_pkg::BUSOFF_OFFSET: next_prdata = {19'h00000, latched_disable,
                                                    run_count, seq_count};
        default: next_pslverr = 1'b1;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_status = can_ctrl_pkg::status_t'(status & ~clear_bits);
    next_status.error = next_status.error | error_event;
    next_status.tx_done = next_status.tx_done | tx_done;
    next_status.rx_done = next_status.rx_done | rx_done;
    next_status.busoff_entry = next_status.busoff_entry | (busoff_entry && bo_state == can_ctrl_pkg::BUS_ON);
    next_status.busoff_exit = next_status.busoff_exit | exit_event;
    eff_mask = irq_enable;
    eff_mask[0] = irq_enable[0] & ctrl.error_irq_mask;
    next_irq = |(status & eff_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= can_ctrl_pkg::CTRL_RESET;
      status <= '0;
      irq_enable <= can_ctrl_pkg::IRQ_ENABLE_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      irq_enable <= next_irq_enable;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // Clock source, loop-back routing and bit sampling
  always_comb begin
    src_tick = ctrl.prescaler_clock_select ? half_toggle : (xtal_sync2 && !xtal_prev);
    rx_src = ctrl.loopback_enable ? tx_bit : rx_sync2;
    next_can_tx = ctrl.loopback_enable ? 1'b1 : tx_bit;
    next_sample_hist = sample_hist;
    if (tq_tick) next_sample_hist = {sample_hist[0], rx_src};
    next_rx_bit_valid = sample_point;
    next_rx_bit = rx_bit;
    if (sample_point) begin
      if (ctrl.loopback_enable && ack_slot) begin
        next_rx_bit = 1'b0;
      end else if (ctrl.triple_sample_enable) begin
        next_rx_bit = can_ctrl_pkg::majority3(sample_hist[1], sample_hist[0], rx_src);
      end else begin
        next_rx_bit = rx_src;
      end
    end
  end

  // Quantum boundaries may jitter with resync; history counts quanta, not bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      xtal_sync1 <= 1'b0;
      xtal_sync2 <= 1'b0;
      xtal_prev <= 1'b0;
      half_toggle <= 1'b0;
      sample_hist <= 2'h3;
      rx_bit <= 1'b1;
      rx_bit_valid <= 1'b0;
      can_tx <= 1'b1;
    end else begin
      rx_sync1 <= can_rx;
      rx_sync2 <= rx_sync1;
      xtal_sync1 <= crystal_clock_input;
      xtal_sync2 <= xtal_sync1;
      xtal_prev <= xtal_sync2;
      half_toggle <= !half_toggle;
      sample_hist <= next_sample_hist;
      rx_bit <= next_rx_bit;
      rx_bit_valid <= next_rx_bit_valid;
      can_tx <= next_can_tx;
    end
  end

  can_prescaler #(
    .DIV_W(8)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .divider(ctrl.serial_clock_divider),
    .tq_tick(tq_tick)
  );

  // Bus off recovery
  always_comb begin
    next_bo_state = bo_state;
    next_latched_disable = latched_disable;
    next_run_count = run_count;
    next_seq_count = seq_count;
    exit_event = 1'b0;
    if (bo_state != can_ctrl_pkg::BUS_ON && rx_bit_valid) begin
      if (!rx_bit) begin
        next_run_count = 4'h0;
      end else if (run_count + 4'h1 == can_ctrl_pkg::RECESSIVE_RUN) begin
        next_run_count = 4'h0;
        if (seq_count < can_ctrl_pkg::BUSOFF_SEQUENCES) next_seq_count = seq_count + 8'h01;
      end else begin
        next_run_count = run_count + 4'h1;
      end
    end
    unique case (bo_state)
      can_ctrl_pkg::BUS_ON: begin
        if (busoff_entry) begin
          next_bo_state = can_ctrl_pkg::BUS_OFF;
          next_latched_disable = ctrl.busoff_autorecover_disable;
          next_run_count = 4'h0;
          next_seq_count = 8'h00;
        end
      end
      can_ctrl_pkg::BUS_OFF: begin
        if (latched_disable) begin
          if (!ctrl.busoff_autorecover_disable) begin
            next_latched_disable = 1'b0;
            if (seq_count >= can_ctrl_pkg::BUSOFF_SEQUENCES) begin
              next_bo_state = can_ctrl_pkg::BUS_REJOIN;
              next_run_count = 4'h0;
            end
          end
        end else if (seq_count >= can_ctrl_pkg::BUSOFF_SEQUENCES) begin
          next_bo_state = can_ctrl_pkg::BUS_ON;
          exit_event = 1'b1;
        end
      end
      can_ctrl_pkg::BUS_REJOIN: begin
        if (rx_bit_valid && rx_bit && run_count + 4'h1 == can_ctrl_pkg::RECESSIVE_RUN) begin
          next_bo_state = can_ctrl_pkg::BUS_ON;
          exit_event = 1'b1;
        end
      end
    endcase
    next_busoff = next_bo_state != can_ctrl_pkg::BUS_ON;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_state <= can_ctrl_pkg::BUS_ON;
      latched_disable <= 1'b0;
      run_count <= 4'h0;
      seq_count <= 8'h00;
      busoff <= 1'b0;
    end else begin
      bo_state <= next_bo_state;
      latched_disable <= next_latched_disable;
      run_count <= next_run_count;
      seq_count <= next_seq_count;
      busoff <= next_busoff;
    end
  end

  // Timer and transmit ordering
  always_comb begin
    next_timer_value = timer_value;
    if (ctrl.timer_sync_on_buffer0 && rx_buffer0_done) begin
      next_timer_value = can_ctrl_pkg::TIMER_RESET;
    end else if (bit_tick) begin
      next_timer_value = timer_value + 16'h0001;
    end
    next_tx_select = pick_buffer(tx_pending, tx_ids, ctrl.tx_order_by_buffer_index);
    next_tx_select_valid = |tx_pending;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_value <= can_ctrl_pkg::TIMER_RESET;
      tx_select <= '0;
      tx_select_valid <= 1'b0;
    end else begin
      timer_value <= next_timer_value;
      tx_select <= next_tx_select;
      tx_select_valid <= next_tx_select_valid;
    end
  end

  a_err_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq && !$past(ctrl.error_irq_mask) |-> $past(|(status[4:1] & irq_enable[4:1])))
    else $error("error interrupt passed while masked");
  a_half_clock_src: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.prescaler_clock_select && $stable(ctrl) && src_tick |-> !$past(src_tick))
    else $error("bus clock source faster than half rate");
  a_loopback_tx: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.loopback_enable |=> can_tx)
    else $error("tx pin not recessive in loop-back");
  a_loopback_ack: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.loopback_enable && ack_slot && sample_point |=> rx_bit_valid && !rx_bit)
    else $error("internal acknowledge missing");
  a_done_flags: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done && rx_done |=> status.tx_done && status.rx_done)
    else $error("completion event lost");
  a_single_sample: assert property (@(posedge pclk) disable iff (!presetn)
    sample_point && !ctrl.triple_sample_enable && !ctrl.loopback_enable
    |=> rx_bit == $past(rx_sync2))
    else $error("single sample mismatch");
  a_triple_sample: assert property (@(posedge pclk) disable iff (!presetn)
    sample_point && ctrl.triple_sample_enable && !ctrl.loopback_enable
    |=> rx_bit == can_ctrl_pkg::majority3($past(sample_hist[1]), $past(sample_hist[0]),
                                          $past(rx_sync2)))
    else $error("majority sample mismatch");
  a_busoff_hold: assert property (@(posedge pclk) disable iff (!presetn)
    bo_state == can_ctrl_pkg::BUS_OFF && latched_disable && ctrl.busoff_autorecover_disable
    |=> busoff [*2])
    else $error("left bus off while recovery disabled");
  a_early_clear: assert property (@(posedge pclk) disable iff (!presetn)
    bo_state == can_ctrl_pkg::BUS_OFF && latched_disable && !ctrl.busoff_autorecover_disable
    && seq_count < can_ctrl_pkg::BUSOFF_SEQUENCES |=> !latched_disable && busoff)
    else $error("early clear did not resume normal recovery");
  a_late_clear: assert property (@(posedge pclk) disable iff (!presetn)
    bo_state == can_ctrl_pkg::BUS_OFF && latched_disable && !ctrl.busoff_autorecover_disable
    && seq_count >= can_ctrl_pkg::BUSOFF_SEQUENCES |=> bo_state == can_ctrl_pkg::BUS_REJOIN)
    else $error("late clear skipped the rejoin wait");
  a_late_set: assert property (@(posedge pclk) disable iff (!presetn)
    bo_state == can_ctrl_pkg::BUS_OFF && !latched_disable |=> !latched_disable)
    else $error("disable set during bus off took effect");
  a_timer_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.timer_sync_on_buffer0 && rx_buffer0_done |=> timer_value == 16'h0000)
    else $error("timer not reset on buffer 0 reception");
  a_index_order: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.tx_order_by_buffer_index && |tx_pending
    |=> tx_select_valid && (($past(tx_pending) & ((NUM_BUFFERS'(1) << tx_select)
        - NUM_BUFFERS'(1))) == '0))
    else $error("lower pending buffer skipped");
  a_timer_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    bit_tick && !(ctrl.timer_sync_on_buffer0 && rx_buffer0_done)
    |=> timer_value == $past(timer_value) + 16'h0001)
    else $error("timer did not advance by one");
  a_seq_saturate: assert property (@(posedge pclk) disable iff (!presetn)
    seq_count <= can_ctrl_pkg::BUSOFF_SEQUENCES)
    else $error("sequence count above saturation");

endmodule : can_control_options

/* can_bus_node.sv */
// Purpose: Far-side CAN node and crystal source
// Assumes: Bus is wired-AND, recessive high
// Notes: Crystal runs free, unrelated to pclk
`timescale 1ns/1ps
module can_bus_node (
  input wire logic can_tx, // Our node's transmit pin
  input wire logic dominant, // Far node pulls the bus low
  output logic can_rx, // Bus level seen at the pin
  output logic crystal_clock_input // Free-running crystal
);
  initial begin
    crystal_clock_input = 1'b0;
    forever #37 crystal_clock_input = ~crystal_clock_input;
  end
  // Idle bus floats recessive through the termination
  assign can_rx = can_tx & ~dominant;
endmodule : can_bus_node

/* can_control_options_tb_top.sv */
// Purpose: Self-checking bench for the CAN control options block
// Assumes: APB master per contract, tx and rx done pulses may share a cycle
// Notes: Bus-off recovery is driven and checked at the end of the bench, with the in-design assertions
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module can_control_options_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, can_rx, can_tx, xtal, dom;
  logic tx_bit, sp, ack, bit_tick, err_ev, tx_done, rx_done, buf0, boff, rxb, rxv, busoff;
  logic tq, irq, selv, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, w;
  logic [3:0] pend;
  logic [3:0][28:0] ids;
  logic [15:0] tval;
  logic [1:0] sel;
  int err_total, tests_run, t, q;
  can_bus_node i_can_bus_node (.can_tx(can_tx), .dominant(dom), .can_rx(can_rx),
    .crystal_clock_input(xtal));
  can_control_options #(.NUM_BUFFERS(4)) i_can_control_options (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock_input(xtal), .can_rx(can_rx), .can_tx(can_tx), .tx_bit(tx_bit),
    .sample_point(sp), .ack_slot(ack), .bit_tick(bit_tick), .error_event(err_ev),
    .tx_done(tx_done), .rx_done(rx_done), .rx_buffer0_done(buf0), .busoff_entry(boff),
    .tx_pending(pend), .tx_ids(ids), .tq_tick(tq), .rx_bit(rxb), .rx_bit_valid(rxv),
    .busoff(busoff), .timer_value(tval), .tx_select(sel), .tx_select_valid(selv), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin err_total++; final_report(); end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic samples(input int n);
    repeat (n) begin sp <= 1'b1; @(posedge pclk); sp <= 1'b0; @(posedge pclk); end
  endtask : samples
  function automatic logic [1:0] pick(input logic [3:0] p, input logic [3:0][28:0] id,
    input logic by_idx);
    logic [1:0] b;
    logic f;
    f = 1'b0; b = 2'h0;
    for (int i = 0; i < 4; i++) if (p[i] && (!f || (!by_idx && id[i] < id[b]))) begin
      b = 2'(i); f = 1'b1;
    end
    return b;
  endfunction : pick
  initial begin
    #500000;
    err_total++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tx_bit, sp, ack, bit_tick} = '0;
    {err_ev, tx_done, rx_done, buf0, boff, pend, ids, dom} = '0;
    void'($urandom(78));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h00, 32'h0); `CHK("ctrl reset", 32'h0000_0000, r)
    apb(0, 8'h40, 32'h0); `CHK("unmapped err", 1'b1, e)
    for (int i = 0; i < 6; i++) begin
      w = ((i == 0) ? 32'hFFFF_FFFF : $urandom()) & 32'hFFFF_F0FF;
      apb(1, 8'h00, w); apb(0, 8'h00, 32'h0);
      `CHK("ctrl rw", w & 32'hFF00_70F0, r)
    end
    $display("Test control register done");
    t = 0;
    for (int s = 0; s < 2; s++) begin
      apb(1, 8'h00, 32'(s) << 5);
      repeat (3) begin bit_tick <= 1'b1; @(posedge pclk); bit_tick <= 1'b0; @(posedge pclk); end
      buf0 <= 1'b1; @(posedge pclk); buf0 <= 1'b0; @(posedge pclk);
      t = (s == 1) ? 0 : t + 3;
      apb(0, 8'h10, 32'h0); `CHK("timer", 32'(t), r)
    end
    $display("Test timer sync done");
    apb(1, 8'h08, 32'h0000_001F);
    for (int m = 0; m < 2; m++) begin
      apb(1, 8'h00, 32'(m) << 14);
      err_ev <= 1'b1; @(posedge pclk); err_ev <= 1'b0; repeat (3) @(posedge pclk);
      `CHK("err irq", 1'(m), irq)
      apb(0, 8'h04, 32'h0); `CHK("err status", 1'b1, r[0])
      apb(1, 8'h0C, 32'h0000_001F); @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
    end
    $display("Test error mask done");
    apb(1, 8'h00, 32'h0000_1000);
    dom <= 1'b1; tx_bit <= 1'b0; repeat (3) @(posedge pclk);
    `CHK("loop tx", 1'b1, can_tx)
    tx_done <= 1'b1; rx_done <= 1'b1; @(posedge pclk); tx_done <= 1'b0; rx_done <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("loop irq", 1'b1, irq)
    apb(0, 8'h04, 32'h0); `CHK("loop status", 2'b11, r[2:1])
    dom <= 1'b0; apb(1, 8'h00, 32'h0); @(posedge pclk);
    `CHK("normal tx", 1'b0, can_tx)
    tx_bit <= 1'b1; apb(1, 8'h0C, 32'h0000_001F);
    $display("Test loop-back done");
    // Source switched only while the link is idle
    apb(1, 8'h00, 32'h0100_2080); dom <= 1'b1; repeat (8) @(posedge pclk);
    q = 0;
    repeat (40) begin @(posedge pclk); q += int'(tq); end
    `CHK("quantum count", 10, q)
    samples(1); `CHK("triple sample", 1'b0, rxb)
    dom <= 1'b0; apb(1, 8'h00, 32'h0); repeat (4) @(posedge pclk);
    samples(1); `CHK("single sample", 1'b1, rxb)
    `CHK("rx valid", 1'b1, rxv)
    dom <= 1'b1; ack <= 1'b1; apb(1, 8'h00, 32'h0000_1000); repeat (4) @(posedge pclk);
    samples(1); `CHK("loop ack", 1'b0, rxb)
    ack <= 1'b0; samples(1); `CHK("loop rx", 1'b1, rxb)
    dom <= 1'b0; apb(1, 8'h00, 32'h0); repeat (4) @(posedge pclk);
    $display("Test sampling done");
    for (int i = 0; i < 12; i++) begin
      apb(1, 8'h00, 32'(i & 1) << 4);
      pend <= (i < 2) ? 4'hF : 4'($urandom_range(1, 15));
      for (int j = 0; j < 4; j++) ids[j] <= (i < 2) ? 29'h0000_0005 : 29'($urandom());
      repeat (3) @(posedge pclk);
      `CHK("tx order", pick(pend, ids, 1'(i & 1)), sel)
      `CHK("tx valid", 1'b1, selv)
    end
    $display("Test tx order done");
    pend <= 4'h0; apb(1, 8'h00, 32'h0);
    boff <= 1'b1; @(posedge pclk); boff <= 1'b0; @(posedge pclk);
    `CHK("busoff entry", 1'b1, busoff)
    samples(1407); `CHK("busoff held", 1'b1, busoff)
    samples(1); repeat (2) @(posedge pclk); `CHK("auto recover", 1'b0, busoff)
    apb(1, 8'h00, 32'h0000_0040);
    boff <= 1'b1; @(posedge pclk); boff <= 1'b0; @(posedge pclk);
    samples(1408); repeat (2) @(posedge pclk); `CHK("recovery held", 1'b1, busoff)
    apb(1, 8'h00, 32'h0); samples(10); `CHK("rejoin wait", 1'b1, busoff)
    samples(1); repeat (2) @(posedge pclk); `CHK("rejoin done", 1'b0, busoff)
    $display("Test bus off done");
    final_report();
  end
endmodule : can_control_options_tb_top
